// ### pkg/adc_ctl_defs.svh
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

// Register offsets
`define OFS_CHANNEL_COMPLETE_STATUS 4'h0
`define OFS_TRIGGER_COMPARE_STATUS  4'h1
`define OFS_RESULT_HIGH             4'h2
`define OFS_RESULT_LOW              4'h3
`define OFS_CONVERSION_CONFIG       4'h6
`define OFS_COMPARE_VALUE_HIGH      4'h4
`define OFS_COMPARE_VALUE_LOW       4'h5
`define OFS_PIN_CTRL_FIRST          4'h7
`define OFS_PIN_CTRL_SECOND         4'h8

// Field positions
`define BIT_LOW_POWER_SEL      7
`define BIT_LONG_SAMPLE_SEL    4
`define BIT_CONV_ACTIVE_FLAG   7
`define BIT_TRIGGER_SELECT     6
`define BIT_COMPARE_ENABLE     5
`define BIT_COMPARE_ABOVE_SEL  4
`define BIT_CONV_COMPLETE_FLAG 7
`define BIT_COMPLETE_IRQ_EN    6
`define BIT_CONTINUOUS_SEL     5
`define CHANNEL_ALL_ONES       5'h1f
`define INPUT_CLOCK_ASYNC      2'h3

// Reset values
`define RST_REG8               8'h00
`define RST_CHANNEL_STATUS     8'h1f

// Conversion timing in clock cycles
`define CONV_CYCLES_SHORT      8'h17
`define CONV_CYCLES_LONG       8'h2b

`endif

// ### pkg/adc_ctl_pkg.sv
package adc_ctl_pkg;

    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_e;

    typedef struct packed
    {
        conv_state_e state;
        logic [7:0]  count;
        logic [7:0]  config_r;
        logic [7:0]  trig_cmp;
        logic [7:0]  chan_stat;
        logic [9:0]  result;
        logic [9:0]  compare_value;
        logic [7:0]  pin_first;
        logic [7:0]  pin_second;
        logic        high_read_pending;
        logic        irq;
        logic [7:0]  rd_data;
    } adc_ctl_s;

endpackage

// ### rtl/adc_lowpower_ctl.sv
// Design decisions made here: the address map and the strobed register port.
`include "adc_ctl_defs.svh"

// Notes on behaviour
// R1: Stop3 without async clock aborts to idle
// R2: Stop3 leaves result registers unchanged
// R3: After abort, wait for new trigger
// R4: Async clock keeps converting through stop3
// R5: Stop3 starts via hardware trigger, continuous
// R6: Completion sets flag, interrupt wakes processor
// R7: Software finishes read pair before stop3
// R8: Stop1/stop2 disables and resets all registers
// R9: Software writes config, status two, status one
// R10: Config bits: low power, divider, sample
// R11: Resolution field at bits 3:2
// R12: Input clock select at bits 1:0
// R13: Status two: active, trigger, compare bits
// R14: Status two bits 3:0 read zero
// R15: Status one: complete flag, irq enable
// R16: Continuous select bit 5, channel 4:0
// R17: Software reads high byte before low
// R18: Compare value holds threshold
// R19: Pin control bits disable digital pin I/O
// R20: Pending high read blocks new result
// R21: Compare gates completion by direction
// R22: Stop abort clears active flag
module adc_lowpower_ctl
#(
    parameter int RESULT_W = 10
)
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic [3:0]          addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [7:0]          rd_data,
    input  wire logic                stop3_mode,
    input  wire logic                stop12_mode,
    input  wire logic                hw_trigger,
    input  wire logic [RESULT_W-1:0] sar_result,
    output logic                     conv_irq,
    output logic      [7:0]          pin_ctrl_first,
    output logic      [7:0]          pin_ctrl_second
);

    // ------------------------------------------------------------
    // State and decode terms
    // ------------------------------------------------------------
    adc_ctl_pkg::adc_ctl_s state_reg;
    adc_ctl_pkg::adc_ctl_s state_next;

    logic                async_sel;
    logic                cont_mode;
    logic                hw_mode;
    logic                chan_off;
    logic                cmp_ok;
    logic                sw_start;
    logic                finish;
    logic [RESULT_W-1:0] diff;
    logic [7:0]          conv_len;
    logic                cmp_en;
    logic                irq_en;
    logic                blocked;
    logic                cmp_fail;
    logic                xfer;
    logic                restart;
    logic                hw_start;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // R12: clock select field
    // R1: abort only without async clock
    assign async_sel = state_reg.config_r[1:0] == `INPUT_CLOCK_ASYNC;
    // R16: continuous select
    assign cont_mode = state_reg.chan_stat[`BIT_CONTINUOUS_SEL];
    // R13: trigger select
    assign hw_mode   = state_reg.trig_cmp[`BIT_TRIGGER_SELECT];
    // R16: channel off code
    assign chan_off  = state_reg.chan_stat[4:0] == `CHANNEL_ALL_ONES;
    // R10: long sample length
    assign conv_len  = state_reg.config_r[`BIT_LONG_SAMPLE_SEL] ? `CONV_CYCLES_LONG : `CONV_CYCLES_SHORT;
    // R21: result minus threshold
    assign diff      = sar_result - state_reg.compare_value;
    // R21: compare direction
    assign cmp_ok    = state_reg.trig_cmp[`BIT_COMPARE_ABOVE_SEL] ?
                       (sar_result >= state_reg.compare_value) : (sar_result < state_reg.compare_value);
    // Last counted cycle of a conversion
    assign finish    = state_reg.state == adc_ctl_pkg::ST_CONV && state_reg.count == 8'h00;
    // R16: software start, channel not off
    assign sw_start  = wr_en && addr == `OFS_CHANNEL_COMPLETE_STATUS && !hw_mode && wr_data[4:0] != `CHANNEL_ALL_ONES;

    // ------------------------------------------------------------
    // Transfer qualification
    // ------------------------------------------------------------
    assign cmp_en    = state_reg.trig_cmp[`BIT_COMPARE_ENABLE];
    assign irq_en    = state_reg.chan_stat[`BIT_COMPLETE_IRQ_EN];
    // R20: high byte read, low byte not yet
    assign blocked   = finish && state_reg.high_read_pending;
    // R21: compare condition failed
    assign cmp_fail  = finish && !state_reg.high_read_pending && cmp_en && !cmp_ok;
    // Result lands in the pair this cycle
    assign xfer      = finish && !state_reg.high_read_pending && !(cmp_en && !cmp_ok);
    // Blocked results retry unless single compare run
    assign restart   = blocked && !(cmp_en && !cont_mode);
    // R5: hardware trigger only from idle
    assign hw_start  = hw_mode && hw_trigger && state_reg.state == adc_ctl_pkg::ST_IDLE && !chan_off;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        // Hold by default; pulses and read data drop
        state_next         = state_reg;
        state_next.irq     = 1'b0;
        state_next.rd_data = `RST_REG8;

        // ------------------------------------------------------------
        // Conversion counter
        // ------------------------------------------------------------
        // Counts down to the end of the conversion
        if (state_next.count != 8'h00)
        begin
            state_next.count = state_reg.count - 8'h01;
        end

        // ------------------------------------------------------------
        // Conversion end
        // ------------------------------------------------------------
        if (finish)
        begin
            state_next.state = adc_ctl_pkg::ST_IDLE;
        end

        // R20: blocked transfer discards result
        if (restart)
        begin
            state_next.state = adc_ctl_pkg::ST_CONV;
            state_next.count = conv_len;
        end

        // R21: no transfer on failed compare
        if (cmp_fail && cont_mode)
        begin
            state_next.state = adc_ctl_pkg::ST_CONV;
            state_next.count = conv_len;
        end

        if (xfer)
        begin
            state_next.result = cmp_en ? diff : sar_result;
            // R6: set flag, wake interrupt
            state_next.chan_stat[`BIT_CONV_COMPLETE_FLAG] = 1'b1;
            state_next.irq = irq_en;
            // R5: continuous restart
            if (cont_mode)
            begin
                state_next.state = adc_ctl_pkg::ST_CONV;
                state_next.count = conv_len;
            end
        end

        // ------------------------------------------------------------
        // Hardware trigger
        // ------------------------------------------------------------
        // R5: hardware trigger start
        if (hw_start)
        begin
            state_next.state = adc_ctl_pkg::ST_CONV;
            state_next.count = conv_len;
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        // Answer stands for one cycle only
        if (rd_en)
        begin
            case (addr)
                `OFS_CHANNEL_COMPLETE_STATUS:
                begin
                    state_next.rd_data = state_reg.chan_stat;
                end
                // R13: active flag readback
                // R14: low bits read zero
                `OFS_TRIGGER_COMPARE_STATUS:
                begin
                    state_next.rd_data = {state_reg.state == adc_ctl_pkg::ST_CONV, state_reg.trig_cmp[6:4], 4'h0};
                end
                // Opens the read pair
                `OFS_RESULT_HIGH:
                begin
                    state_next.rd_data = {6'h00, state_reg.result[9:8]};
                    state_next.high_read_pending = 1'b1;
                end
                // Closes the read pair
                `OFS_RESULT_LOW:
                begin
                    state_next.rd_data = state_reg.result[7:0];
                    state_next.high_read_pending = 1'b0;
                    // A completion in this cycle keeps its flag
                    if (!xfer)
                    begin
                        state_next.chan_stat[`BIT_CONV_COMPLETE_FLAG] = 1'b0;
                    end
                end
                `OFS_COMPARE_VALUE_HIGH:
                begin
                    state_next.rd_data = {6'h00, state_reg.compare_value[9:8]};
                end
                `OFS_COMPARE_VALUE_LOW:
                begin
                    state_next.rd_data = state_reg.compare_value[7:0];
                end
                `OFS_CONVERSION_CONFIG:
                begin
                    state_next.rd_data = state_reg.config_r;
                end
                `OFS_PIN_CTRL_FIRST:
                begin
                    state_next.rd_data = state_reg.pin_first;
                end
                `OFS_PIN_CTRL_SECOND:
                begin
                    state_next.rd_data = state_reg.pin_second;
                end
                default:
                begin
                    state_next.rd_data = `RST_REG8;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        // Any mode change aborts the running conversion
        if (wr_en)
        begin
            case (addr)
                `OFS_CHANNEL_COMPLETE_STATUS:
                begin
                    // R15: flag cannot be set by software, any write clears it
                    // R16: mode and channel
                    state_next.chan_stat = {1'b0, wr_data[6:0]};
                    // Starts anew unless channel is off or hardware trigger is selected
                    state_next.state = sw_start ? adc_ctl_pkg::ST_CONV : adc_ctl_pkg::ST_IDLE;
                    state_next.count = conv_len;
                end
                `OFS_TRIGGER_COMPARE_STATUS:
                begin
                    // R13: writable control bits
                    // R14: reserved bits kept zero
                    state_next.trig_cmp = {1'b0, wr_data[6:4], 4'h0};
                    state_next.state = adc_ctl_pkg::ST_IDLE;
                end
                `OFS_CONVERSION_CONFIG:
                begin
                    // R10: config fields
                    // R11: resolution field stored
                    state_next.config_r = wr_data;
                    state_next.state = adc_ctl_pkg::ST_IDLE;
                end
                // R18: threshold storage
                `OFS_COMPARE_VALUE_HIGH:
                begin
                    state_next.compare_value[9:8] = wr_data[1:0];
                    state_next.state = adc_ctl_pkg::ST_IDLE;
                end
                `OFS_COMPARE_VALUE_LOW:
                begin
                    state_next.compare_value[7:0] = wr_data;
                    state_next.state = adc_ctl_pkg::ST_IDLE;
                end
                // R19: pin control
                `OFS_PIN_CTRL_FIRST:
                begin
                    state_next.pin_first = wr_data;
                end
                `OFS_PIN_CTRL_SECOND:
                begin
                    state_next.pin_second = wr_data;
                end
                // Unmapped or result index, write ignored
                default:
                begin
                    state_next.pin_second = state_reg.pin_second;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Low-power modes
        // ------------------------------------------------------------
        // R1: abort in stop3 without async clock
        // R4: async clock keeps running
        // R2: result untouched here
        // R3: idle until new trigger
        // R22: active flag drops on abort
        if (stop3_mode && !async_sel)
        begin
            state_next.state = adc_ctl_pkg::ST_IDLE;
            state_next.count = 8'h00;
        end

        // R8: stop1/stop2 reset everything
        // Acts as a synchronous register reset
        if (stop12_mode)
        begin
            state_next = '0;
            state_next.chan_stat = `RST_CHANNEL_STATUS;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Channel field resets to off
            state_reg           <= '0;
            state_reg.chan_stat <= `RST_CHANNEL_STATUS;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Each output taken straight from the state flops
    assign rd_data         = state_reg.rd_data;
    assign conv_irq        = state_reg.irq;
    assign pin_ctrl_first  = state_reg.pin_first;
    assign pin_ctrl_second = state_reg.pin_second;

endmodule

// ### tb/adc_ctl_properties.sv
module adc_ctl_properties
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    input wire logic       stop12_mode,
    input wire logic       conv_irq,
    input wire logic [7:0] pin_ctrl_first,
    input wire logic [7:0] pin_ctrl_second
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----------
    // Properties
    // ----------
    chk_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not zero outside answer cycle");
    chk_unmapped_zero: assert property (rd_en && addr > 4'h8 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    chk_sc2_res_zero: assert property (rd_en && addr == 4'h1 |=> rd_data[3:2] == 2'h0)
        else $error("status two bits 3:2 not zero");
    chk_cfg_readback: assert property ((wr_en && addr == 4'h6 && !stop12_mode) ##1 !stop12_mode
        ##1 (rd_en && addr == 4'h6 && !stop12_mode) |=> rd_data == $past(wr_data, 3))
        else $error("config readback differs");
    chk_pin_write: assert property (wr_en && addr == 4'h7 && !stop12_mode |=> pin_ctrl_first == $past(wr_data))
        else $error("pin control not updated");
    chk_stop12_clear: assert property (stop12_mode |=> pin_ctrl_first == 8'h00 && pin_ctrl_second == 8'h00)
        else $error("pin control kept through stop1/2");
    chk_irq_pulse: assert property (conv_irq |=> !conv_irq)
        else $error("interrupt longer than one cycle");
    chk_irq_not_early: assert property (wr_en && addr == 4'h0 |=> ##1 !conv_irq [*8])
        else $error("interrupt too soon after start");
endmodule

bind adc_lowpower_ctl adc_ctl_properties adc_ctl_properties_i
(
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .stop12_mode(stop12_mode), .conv_irq(conv_irq), .pin_ctrl_first(pin_ctrl_first),
    .pin_ctrl_second(pin_ctrl_second)
);

// ### tb/adc_lowpower_ctl_tb.sv
module adc_lowpower_ctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys     = 1'b0;
    logic       rst_n       = 1'b0;
    logic [3:0] addr        = 4'h0;
    logic [7:0] wr_data     = 8'h00;
    logic       wr_en       = 1'b0;
    logic       rd_en       = 1'b0;
    logic       stop3_mode  = 1'b0;
    logic       stop12_mode = 1'b0;
    logic       hw_trigger  = 1'b0;
    logic [9:0] sar_result  = 10'h000;
    logic [7:0] rd_data;
    logic       conv_irq;
    logic [7:0] pin_ctrl_first;
    logic [7:0] pin_ctrl_second;
    int         err_total   = 0;
    int         checks_done = 0;

    always #2.5 clk_sys = ~clk_sys;

    adc_lowpower_ctl adc_lowpower_ctl_i
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .stop3_mode(stop3_mode), .stop12_mode(stop12_mode), .hw_trigger(hw_trigger),
        .sar_result(sar_result), .conv_irq(conv_irq), .pin_ctrl_first(pin_ctrl_first),
        .pin_ctrl_second(pin_ctrl_second)
    );

    // ---------------
    // Bus and helpers
    // ---------------
    task conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk8(rd_data, exp);
    endtask
    task wait_irq();
        int i;
        for (i = 0; i < 200 && conv_irq !== 1'b1; i++)
            @(negedge clk_sys);
        chk8({7'h00, conv_irq}, 8'h01);
        if (conv_irq !== 1'b1)
            conclude();
    endtask
    task setup(input logic [7:0] cfg, input logic [7:0] sc2, input logic [9:0] res);
        @(posedge clk_sys);
        sar_result <= res;
        wr(4'h6, cfg);
        wr(4'h1, sc2);
    endtask

    // ---------
    // Scenarios
    // ---------
    task t_regs();
        rd(4'h0, 8'h1f);
        rd(4'h1, 8'h00);
        rd(4'hf, 8'h00);
        wr(4'h6, 8'h98);
        rd(4'h6, 8'h98);
        wr(4'h1, 8'h3c);
        rd(4'h1, 8'h30);
        wr(4'h7, 8'h02);
        chk8(pin_ctrl_first, 8'h02);
        chk8(pin_ctrl_second, 8'h00);
        $display("done regs");
    endtask
    task t_single();
        setup(8'h00, 8'h00, 10'h2a5);
        wr(4'h0, 8'h41);
        rd(4'h1, 8'h80);
        wait_irq();
        rd(4'h0, 8'hc1);
        rd(4'h2, 8'h02);
        rd(4'h3, 8'ha5);
        rd(4'h0, 8'h41);
        $display("done single");
    endtask
    task t_abort();
        setup(8'h00, 8'h00, 10'h0ff);
        wr(4'h0, 8'h01);
        idle(3);
        stop3_mode <= 1'b1;
        idle(4);
        stop3_mode <= 1'b0;
        rd(4'h1, 8'h00);
        idle(60);
        rd(4'h0, 8'h01);
        rd(4'h2, 8'h02);
        rd(4'h3, 8'ha5);
        $display("done abort");
    endtask
    task t_async();
        setup(8'h03, 8'h00, 10'h155);
        rd(4'h3, 8'ha5);
        wr(4'h0, 8'h41);
        @(posedge clk_sys);
        stop3_mode <= 1'b1;
        wait_irq();
        rd(4'h2, 8'h01);
        rd(4'h3, 8'h55);
        setup(8'h03, 8'h40, 10'h0aa);
        wr(4'h0, 8'h40);
        idle(40);
        rd(4'h1, 8'h40);
        @(posedge clk_sys);
        hw_trigger <= 1'b1;
        @(posedge clk_sys);
        hw_trigger <= 1'b0;
        wait_irq();
        rd(4'h2, 8'h00);
        rd(4'h3, 8'haa);
        @(posedge clk_sys);
        stop3_mode <= 1'b0;
        $display("done async");
    endtask
    task t_cmp();
        setup(8'h00, 8'h20, 10'h155);
        wr(4'h4, 8'h01);
        wr(4'h5, 8'h00);
        wr(4'h0, 8'h01);
        idle(60);
        rd(4'h0, 8'h01);
        @(posedge clk_sys);
        sar_result <= 10'h0ff;
        wr(4'h0, 8'h41);
        wait_irq();
        rd(4'h2, 8'h03);
        rd(4'h3, 8'hff);
        $display("done compare");
    endtask
    task t_block();
        setup(8'h00, 8'h00, 10'h123);
        rd(4'h2, 8'h03);
        wr(4'h0, 8'h41);
        idle(30);
        rd(4'h0, 8'h41);
        rd(4'h3, 8'hff);
        wait_irq();
        rd(4'h2, 8'h01);
        rd(4'h3, 8'h23);
        $display("done block");
    endtask
    task t_cont();
        setup(8'h00, 8'h00, 10'h0c3);
        wr(4'h0, 8'h61);
        wait_irq();
        rd(4'h2, 8'h00);
        rd(4'h3, 8'hc3);
        @(posedge clk_sys);
        sar_result <= 10'h23c;
        wait_irq();
        rd(4'h2, 8'h02);
        rd(4'h3, 8'h3c);
        wr(4'h0, 8'h1f);
        rd(4'h1, 8'h00);
        $display("done continuous");
    endtask
    task t_stop12();
        @(posedge clk_sys);
        stop12_mode <= 1'b1;
        @(posedge clk_sys);
        stop12_mode <= 1'b0;
        rd(4'h6, 8'h00);
        rd(4'h0, 8'h1f);
        chk8(pin_ctrl_first, 8'h00);
        $display("done stop12");
    endtask

    initial
    begin
        idle(4);
        rst_n <= 1'b1;
        t_regs();
        t_single();
        t_abort();
        t_async();
        t_cmp();
        t_block();
        t_cont();
        t_stop12();
        conclude();
    end
endmodule
